// ==== tcbr_map.svh ====
`ifndef TCBR_MAP_SVH
`define TCBR_MAP_SVH
// register byte offsets in the debug segment
`define TCBR_OFS_WORD_LO 14'h3F80
`define TCBR_OFS_WORD_HI 14'h3F84
`define TCBR_OFS_RDP     14'h3F88
`define TCBR_OFS_WRP     14'h3F90
`define TCBR_OFS_CTL     14'h3FC0
// control field positions
`define TCBR_BIT_ILLEGAL 31
`define TCBR_BIT_XFDT    15
`define TCBR_BIT_CYC     14
`define TCBR_BIT_FDT     13
`define TCBR_BIT_BM      12
`define TCBR_BIT_ER      11
`define TCBR_BIT_FCR     10
`define TCBR_BIT_EST     9
`define TCBR_SYP_HI      8
`define TCBR_SYP_LO      5
`define TCBR_BIT_OFFCHIP_CLOCK_RATIO   4
`define TCBR_BIT_OFC     3
`define TCBR_BIT_IO      2
`define TCBR_BIT_EN      1
`define TCBR_BIT_ON      0
// reset values
`define TCBR_CTL_RESET   32'h0000_0000
`define TCBR_PTR_RESET   32'h0000_0000
// memory geometry: 2**TCBR_MEM_AW words of 64 bits
`define TCBR_MEM_AW      8
`define TCBR_SYP_BASE    8
`endif

// ==== tcbr_pkg.sv ====
package tcbr_pkg;
  typedef logic [31:0] tcbr_word_t;
  typedef logic [63:0] tcbr_trace_t;
  typedef logic [13:0] tcbr_addr_t;
  typedef logic [7:0]  tcbr_idx_t;
  typedef enum logic [2:0] {
    TCBR_OUT_IDLE   = 3'b001,
    TCBR_OUT_FDT    = 3'b010,
    TCBR_OUT_BM     = 3'b100
  } tcbr_seq_e;
endpackage : tcbr_pkg

// ==== tcbr_mem_if.sv ====
`timescale 1ns/100ps
`default_nettype none
// write and read sides of the circular trace memory
interface tcbr_mem_if;
  import tcbr_pkg::*;
  logic        wr_en;
  tcbr_idx_t   wr_idx;
  tcbr_trace_t wr_data;
  tcbr_idx_t   rd_idx;
  tcbr_trace_t rd_data;
  modport ctrl (output wr_en, output wr_idx, output wr_data, output rd_idx, input rd_data);
  modport mem  (input wr_en, input wr_idx, input wr_data, input rd_idx, output rd_data);
endinterface : tcbr_mem_if
`default_nettype wire

// ==== tcbr_mem.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "tcbr_map.svh"
module tcbr_mem (
  input wire logic clk_in,
  tcbr_mem_if.mem  port_if
);
  import tcbr_pkg::*;
  tcbr_trace_t store [0:(1<<`TCBR_MEM_AW)-1];
  // synchronous write, asynchronous read
  always_ff @(posedge clk_in) begin
    if (port_if.wr_en) begin
      store[port_if.wr_idx] <= port_if.wr_data;
    end
  end
  assign port_if.rd_data = store[port_if.rd_idx];
endmodule : tcbr_mem
`default_nettype wire

// ==== tcbr_sync.sv ====
`timescale 1ns/100ps
`default_nettype none
// two-stage synchroniser for trigger pins
module tcbr_sync (
  input  wire logic clk_in,
  input  wire logic rst_b_in,
  input  wire logic d_in,
  output logic      q_out
);
  logic stage1;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      stage1 <= 1'b0;
      q_out  <= 1'b0;
    end else begin
      stage1 <= d_in;
      q_out  <= stage1;
    end
  end
endmodule : tcbr_sync
`default_nettype wire

// ==== trace_control_buffer_regs.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "tcbr_map.svh"
module trace_control_buffer_regs #(
  parameter bit HAS_SPECIAL = 1'b1,
  parameter bit HAS_CYC     = 1'b1,
  parameter bit HAS_ONCHIP  = 1'b1,
  parameter bit HAS_OFFCHIP = 1'b1,
  parameter bit OFC_PRESET  = 1'b0
) (
  input  wire logic              clk_in,
  input  wire logic              rst_b_in,
  input  wire logic              reg_rd_in,
  input  wire logic              reg_wr_in,
  input  wire tcbr_pkg::tcbr_addr_t reg_addr_in,
  input  wire tcbr_pkg::tcbr_word_t reg_wdata_in,
  output tcbr_pkg::tcbr_word_t   reg_rdata_out,
  input  wire logic              trace_on_trig_in,
  input  wire logic              trace_off_trig_in,
  input  wire logic              word_valid_in,
  input  wire tcbr_pkg::tcbr_trace_t word_data_in,
  input  wire logic              partial_valid_in,
  input  wire tcbr_pkg::tcbr_trace_t partial_data_in,
  input  wire logic              sync_tick_in,
  input  wire logic              msg_tick_in,
  input  wire logic              fdt_match_in,
  output logic                   normal_enable_out,
  output logic                   fdt_enable_out,
  output logic                   bm_enable_out,
  output logic                   er_enable_out,
  output logic                   fcr_enable_out,
  output logic                   cyc_include_out,
  output logic [9:0]             delta_cycle_out,
  output logic                   seq_fdt_out,
  output logic                   seq_bm_out,
  output logic                   sync_due_out,
  output logic                   offchip_enable_out,
  output logic [2:0]             trace_clk_div_out,
  output logic                   cpu_stall_out,
  output logic                   flush_out,
  output logic                   collect_out
);
  import tcbr_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // control register and memory
  tcbr_word_t  ctl;
  tcbr_idx_t   rd_ptr;
  tcbr_idx_t   wr_ptr;
  logic        wrap_flag;
  logic        on_q;
  logic        trig_on;
  logic        trig_off;
  logic        illegal;
  logic        mem_full;
  logic        store_now;
  tcbr_trace_t store_data;
  logic [23:0] sync_cnt;
  logic [23:0] sync_limit;
  logic [9:0]  delta_cnt;
  tcbr_seq_e   seq;
  tcbr_seq_e   next_seq;
  tcbr_mem_if  mem_if ();

  tcbr_mem u_mem (
    .clk_in  (clk_in),
    .port_if (mem_if.mem)
  );
  tcbr_sync u_sync_on (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .d_in     (trace_on_trig_in),
    .q_out    (trig_on)
  );
  tcbr_sync u_sync_off (
    .clk_in   (clk_in),
    .rst_b_in (rst_b_in),
    .d_in     (trace_off_trig_in),
    .q_out    (trig_off)
  );

  // decode a register address
  function automatic logic hit(input tcbr_addr_t a, input tcbr_addr_t ofs);
    hit = (a == ofs);
  endfunction : hit

  logic wr_ctl;
  logic wr_rdp;
  logic wr_wrp;
  logic rd_lo;
  assign wr_ctl = reg_wr_in && hit(reg_addr_in, `TCBR_OFS_CTL);
  assign wr_rdp = reg_wr_in && hit(reg_addr_in, `TCBR_OFS_RDP);
  assign wr_wrp = reg_wr_in && hit(reg_addr_in, `TCBR_OFS_WRP);
  assign rd_lo  = reg_rd_in && hit(reg_addr_in, `TCBR_OFS_WORD_LO);

  // illegal mix: several exclusive special modes or modes without enable
  always_comb begin
    illegal = 1'b0;
    if (!ctl[`TCBR_BIT_EST] && (ctl[`TCBR_BIT_FDT] || ctl[`TCBR_BIT_BM] ||
        ctl[`TCBR_BIT_ER] || ctl[`TCBR_BIT_FCR] || ctl[`TCBR_BIT_CYC])) begin
      illegal = 1'b1;
    end else if ((ctl[`TCBR_BIT_FDT] && ctl[`TCBR_BIT_BM]) ||
        ((ctl[`TCBR_BIT_FDT] || ctl[`TCBR_BIT_BM]) &&
        (ctl[`TCBR_BIT_ER] || ctl[`TCBR_BIT_FCR]))) begin
      illegal = 1'b1;
    end
  end

  // software fields; unimplemented modes stay zero
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      ctl <= `TCBR_CTL_RESET;
    end else if (wr_ctl) begin
      ctl[`TCBR_BIT_XFDT] <= HAS_SPECIAL & reg_wdata_in[`TCBR_BIT_XFDT];
      ctl[`TCBR_BIT_CYC]  <= HAS_CYC & reg_wdata_in[`TCBR_BIT_CYC];
      ctl[`TCBR_BIT_FDT]  <= HAS_SPECIAL & reg_wdata_in[`TCBR_BIT_FDT];
      ctl[`TCBR_BIT_BM]   <= HAS_SPECIAL & reg_wdata_in[`TCBR_BIT_BM];
      ctl[`TCBR_BIT_ER]   <= HAS_SPECIAL & reg_wdata_in[`TCBR_BIT_ER];
      ctl[`TCBR_BIT_FCR]  <= HAS_SPECIAL & reg_wdata_in[`TCBR_BIT_FCR];
      ctl[`TCBR_BIT_EST]  <= HAS_SPECIAL & reg_wdata_in[`TCBR_BIT_EST];
      ctl[`TCBR_SYP_HI:`TCBR_SYP_LO] <= reg_wdata_in[`TCBR_SYP_HI:`TCBR_SYP_LO];
      ctl[`TCBR_BIT_OFFCHIP_CLOCK_RATIO] <= reg_wdata_in[`TCBR_BIT_OFFCHIP_CLOCK_RATIO];
      ctl[`TCBR_BIT_IO]    <= reg_wdata_in[`TCBR_BIT_IO];
      ctl[`TCBR_BIT_EN]    <= reg_wdata_in[`TCBR_BIT_EN];
      ctl[`TCBR_BIT_ON]    <= reg_wdata_in[`TCBR_BIT_ON];
    end else if (trig_on) begin
      ctl[`TCBR_BIT_EN] <= 1'b1;
    end else if (trig_off) begin
      ctl[`TCBR_BIT_EN] <= 1'b0;
    end
  end

  // offchip bit writable only with both storage modes
  logic offchip_enable;
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      offchip_enable <= 1'b0;
    end else if (!(HAS_ONCHIP && HAS_OFFCHIP)) begin
      offchip_enable <= OFC_PRESET;
    end else if (wr_ctl) begin
      offchip_enable <= reg_wdata_in[`TCBR_BIT_OFC];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // trace collection, flush and circular storage
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      on_q <= 1'b0;
    end else begin
      on_q <= ctl[`TCBR_BIT_ON];
    end
  end

  assign mem_full = wrap_flag && (wr_ptr == rd_ptr);
  // partial word goes to memory only on collection falling edge
  always_comb begin
    store_now  = 1'b0;
    store_data = word_data_in;
    if (on_q && !ctl[`TCBR_BIT_ON] && partial_valid_in) begin
      store_now  = 1'b1;
      store_data = partial_data_in;
    end else if (ctl[`TCBR_BIT_ON] && word_valid_in) begin
      store_now  = 1'b1;
    end
  end

  assign mem_if.wr_en   = store_now;
  assign mem_if.wr_idx  = wr_ptr;
  assign mem_if.wr_data = store_data;
  assign mem_if.rd_idx  = rd_ptr;

  // write pointer advances one word; wrap sets flag, set beats clear
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      wr_ptr    <= 8'h00;
      wrap_flag <= 1'b0;
    end else begin
      if (store_now) begin
        wr_ptr <= wr_ptr + 8'h01;
      end else if (wr_wrp) begin
        wr_ptr <= reg_wdata_in[`TCBR_MEM_AW+2:3];
      end
      if (store_now && (wr_ptr == 8'hFF)) begin
        wrap_flag <= 1'b1;
      end else if (wr_wrp) begin
        wrap_flag <= 1'b0;
      end
    end
  end

  // read pointer steps on lower-half read, wraps to zero
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rd_ptr <= 8'h00;
    end else if (wr_rdp) begin
      rd_ptr <= reg_wdata_in[`TCBR_MEM_AW+2:3];
    end else if (rd_lo) begin
      rd_ptr <= rd_ptr + 8'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read data mux
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      reg_rdata_out <= 32'h0000_0000;
    end else if (!reg_rd_in) begin
      reg_rdata_out <= 32'h0000_0000;
    end else if (hit(reg_addr_in, `TCBR_OFS_CTL)) begin
      reg_rdata_out <= {illegal, 15'h0000, ctl[15:4], offchip_enable, ctl[2:0]};
    end else if (hit(reg_addr_in, `TCBR_OFS_WORD_LO)) begin
      reg_rdata_out <= mem_if.rd_data[31:0];
    end else if (hit(reg_addr_in, `TCBR_OFS_WORD_HI)) begin
      reg_rdata_out <= mem_if.rd_data[63:32];
    end else if (hit(reg_addr_in, `TCBR_OFS_RDP)) begin
      reg_rdata_out <= {21'h000000, rd_ptr, 3'h0};
    end else if (hit(reg_addr_in, `TCBR_OFS_WRP)) begin
      reg_rdata_out <= {wrap_flag, 20'h00000, wr_ptr, 3'h0};
    end else begin
      reg_rdata_out <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sync period and delta cycle counters
  always_comb begin
    sync_limit = 24'h000000;
    sync_limit[5'(ctl[`TCBR_SYP_HI:`TCBR_SYP_LO]) + 5'(`TCBR_SYP_BASE)] = 1'b1; // 5-bit sum
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      sync_cnt     <= 24'h000000;
      sync_due_out <= 1'b0;
    end else if (sync_tick_in) begin
      sync_due_out <= (sync_cnt == sync_limit - 24'h000001);
      sync_cnt <= (sync_cnt == sync_limit - 24'h000001) ? 24'h000000 : sync_cnt + 24'h000001;
    end else begin
      sync_due_out <= 1'b0;
    end
  end

  // cycles since last message; TCBR_OUT_FDT step of extended sequence forces zero
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      delta_cnt       <= 10'h000;
      delta_cycle_out <= 10'h000;
    end else if (msg_tick_in) begin
      delta_cycle_out <= (seq == TCBR_OUT_FDT) ? 10'h000 : delta_cnt;
      delta_cnt       <= 10'h001;
    end else begin
      delta_cnt <= delta_cnt + 10'h001;
    end
  end

  // extended filtered data: value message then match message
  always_comb begin
    next_seq = seq;
    case (seq)
      TCBR_OUT_IDLE: begin
        if (fdt_match_in && ctl[`TCBR_BIT_FDT] && ctl[`TCBR_BIT_XFDT]) begin
          next_seq = TCBR_OUT_FDT;
        end
      end
      TCBR_OUT_FDT: next_seq = TCBR_OUT_BM;
      TCBR_OUT_BM: next_seq = TCBR_OUT_IDLE;
      default: next_seq = TCBR_OUT_IDLE;
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      seq <= TCBR_OUT_IDLE;
    end else begin
      seq <= next_seq;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // registered mode outputs
  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      normal_enable_out  <= 1'b0;
      fdt_enable_out     <= 1'b0;
      bm_enable_out      <= 1'b0;
      er_enable_out      <= 1'b0;
      fcr_enable_out     <= 1'b0;
      cyc_include_out    <= 1'b0;
      seq_fdt_out        <= 1'b0;
      seq_bm_out         <= 1'b0;
      offchip_enable_out <= 1'b0;
      trace_clk_div_out  <= 3'h4;
      cpu_stall_out      <= 1'b0;
      flush_out          <= 1'b0;
      collect_out        <= 1'b0;
    end else begin
      normal_enable_out  <= ctl[`TCBR_BIT_EN] && !ctl[`TCBR_BIT_EST];
      fdt_enable_out     <= ctl[`TCBR_BIT_EST] && ctl[`TCBR_BIT_FDT];
      bm_enable_out      <= ctl[`TCBR_BIT_EST] && ctl[`TCBR_BIT_BM];
      er_enable_out      <= ctl[`TCBR_BIT_EST] && ctl[`TCBR_BIT_ER];
      fcr_enable_out     <= ctl[`TCBR_BIT_EST] && ctl[`TCBR_BIT_FCR];
      cyc_include_out    <= ctl[`TCBR_BIT_EST] && ctl[`TCBR_BIT_CYC];
      seq_fdt_out        <= (next_seq == TCBR_OUT_FDT);
      seq_bm_out         <= (next_seq == TCBR_OUT_BM);
      offchip_enable_out <= offchip_enable;
      trace_clk_div_out  <= (offchip_enable && ctl[`TCBR_BIT_OFFCHIP_CLOCK_RATIO]) ? 3'h2 : 3'h4;
      cpu_stall_out      <= offchip_enable && ctl[`TCBR_BIT_IO] && mem_full;
      flush_out          <= on_q && !ctl[`TCBR_BIT_ON];
      collect_out        <= ctl[`TCBR_BIT_ON] && ctl[`TCBR_BIT_EN];
    end
  end
endmodule : trace_control_buffer_regs
`default_nettype wire

// ==== tcbr_checker.sv ====
`timescale 1ns/100ps
`default_nettype none
module tcbr_checker (
  input wire logic                 clk_in,
  input wire logic                 rst_b_in,
  input wire logic                 reg_rd_in,
  input wire tcbr_pkg::tcbr_word_t reg_rdata_out,
  input wire logic                 normal_enable_out,
  input wire logic                 fdt_enable_out,
  input wire logic                 bm_enable_out,
  input wire logic                 er_enable_out,
  input wire logic                 cyc_include_out,
  input wire logic                 seq_fdt_out,
  input wire logic                 seq_bm_out,
  input wire logic                 sync_due_out,
  input wire logic                 offchip_enable_out,
  input wire logic [2:0]           trace_clk_div_out,
  input wire logic                 cpu_stall_out,
  input wire logic                 flush_out,
  input wire logic                 collect_out
);
  import tcbr_pkg::*;
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!rst_b_in);
  ////////////////////////////////////////////////////////////////////////////////
  // read data only in the cycle after a read strobe
  AST_RDATA_IDLE: assert property (!$past(reg_rd_in) |-> reg_rdata_out == 32'h0)
    else $error("read data not zero without a read");
  // special modes keep normal tracing off
  AST_FDT_SUPPRESS: assert property (fdt_enable_out |-> !normal_enable_out)
    else $error("normal tracing alongside filtered data");
  AST_BM_SUPPRESS: assert property (bm_enable_out |-> !normal_enable_out)
    else $error("normal tracing alongside breakpoint match");
  AST_ER_SUPPRESS: assert property (er_enable_out |-> !normal_enable_out)
    else $error("normal tracing alongside exception markers");
  AST_CYC_SPECIAL: assert property (cyc_include_out |-> !normal_enable_out)
    else $error("delta cycle outside special tracing");
  // clock ratio and stall only count in off-chip mode
  AST_CLK_DIV: assert property (!offchip_enable_out |-> trace_clk_div_out == 3'h4)
    else $error("clock ratio applied without off-chip mode");
  AST_STALL_OFC: assert property (cpu_stall_out |-> offchip_enable_out)
    else $error("stall without off-chip mode");
  // flush is one pulse with collection stopped
  AST_FLUSH_PULSE: assert property (flush_out |=> !flush_out)
    else $error("flush longer than one cycle");
  AST_FLUSH_STOP: assert property (flush_out |-> !collect_out)
    else $error("flush while collecting");
  AST_SYNC_PULSE: assert property (sync_due_out |=> !sync_due_out)
    else $error("sync request longer than one cycle");
  // filtered data message is followed at once by the match message
  AST_SEQ_ORDER: assert property (seq_fdt_out |=> seq_bm_out)
    else $error("match message does not follow filtered data");
  // main scenarios
  COV_FLUSH: cover property (flush_out);
  COV_SEQ: cover property (seq_bm_out);
  COV_SYNC: cover property (sync_due_out);
  COV_STALL: cover property (cpu_stall_out);
endmodule : tcbr_checker
bind trace_control_buffer_regs tcbr_checker tcbr_checker_i (.clk_in, .rst_b_in, .reg_rd_in,
  .reg_rdata_out, .normal_enable_out, .fdt_enable_out, .bm_enable_out, .er_enable_out,
  .cyc_include_out, .seq_fdt_out, .seq_bm_out, .sync_due_out, .offchip_enable_out,
  .trace_clk_div_out, .cpu_stall_out, .flush_out, .collect_out);
`default_nettype wire

// ==== tb_trace_control_buffer_regs.sv ====
`timescale 1ns/100ps
`default_nettype none
`include "tcbr_map.svh"
module tb_trace_control_buffer_regs;
  import tcbr_pkg::*;
  logic        clk_in, rst_b_in, rd, wr, on_t, off_t, wv, pv, st, mt, fm;
  tcbr_addr_t  addr;
  tcbr_word_t  wd, rdat, q;
  tcbr_trace_t wdat, pdat;
  logic        ne, fe, be, ee, ce, cy, sf, sb, sd, oe, stl, fl, co;
  logic [9:0]  dc;
  logic [2:0]  div;
  int          err_count, cmp_count, n;
  trace_control_buffer_regs trace_control_buffer_regs_i (
    .clk_in(clk_in), .rst_b_in(rst_b_in), .reg_rd_in(rd), .reg_wr_in(wr),
    .reg_addr_in(addr), .reg_wdata_in(wd), .reg_rdata_out(rdat),
    .trace_on_trig_in(on_t), .trace_off_trig_in(off_t), .word_valid_in(wv),
    .word_data_in(wdat), .partial_valid_in(pv), .partial_data_in(pdat),
    .sync_tick_in(st), .msg_tick_in(mt), .fdt_match_in(fm),
    .normal_enable_out(ne), .fdt_enable_out(fe), .bm_enable_out(be), .er_enable_out(ee),
    .fcr_enable_out(ce), .cyc_include_out(cy), .delta_cycle_out(dc), .seq_fdt_out(sf),
    .seq_bm_out(sb), .sync_due_out(sd), .offchip_enable_out(oe), .trace_clk_div_out(div),
    .cpu_stall_out(stl), .flush_out(fl), .collect_out(co));
  ////////////////////////////////////////////////////////////////////////////////
  // core clock, 40 ns
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  // verdict and end of run
  task automatic end_of_test;
    if (err_count == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test
  // value compare
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // idle cycles, ending just after an edge
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_in);
    #1;
  endtask : cyc
  // register write strobe
  task automatic wreg(input tcbr_addr_t a, input tcbr_word_t d);
    addr = a;
    wd = d;
    wr = 1'b1;
    @(posedge clk_in);
    #1 wr = 1'b0;
    cyc(1);
  endtask : wreg
  // register read and compare
  task automatic rc(input string nm, input tcbr_addr_t a, input tcbr_word_t e);
    addr = a;
    rd = 1'b1;
    @(posedge clk_in);
    #1 rd = 1'b0;
    q = rdat;
    chk(nm, e, q);
    cyc(1);
  endtask : rc
  // completed trace words, one per cycle
  task automatic push(input int k);
    wv = 1'b1;
    for (int i = 0; i < k; i++) begin
      wdat = {32'hA5A5_0000 + 32'(i), 32'h5A5A_0000 + 32'(i)};
      cyc(1);
    end
    wv = 1'b0;
  endtask : push
  ////////////////////////////////////////////////////////////////////////////////
  // hang guard
  initial begin
    repeat (20000) @(posedge clk_in);
    err_count++;
    end_of_test();
  end
  // main sequence
  initial begin
    {rd, wr, on_t, off_t, wv, pv, st, mt, fm} = '0;
    addr = '0;
    wd = '0;
    wdat = '0;
    pdat = 64'hFFFF_FFFF_0000_00C3;
    rst_b_in = 1'b0;
    repeat (8) @(posedge clk_in);
    #1 rst_b_in = 1'b1;
    chk("div_rst", 32'h4, 32'(div));
    rc("ctl_rst", `TCBR_OFS_CTL, 32'h0);
    wreg(`TCBR_OFS_CTL, 32'h0000_FFFF);
    rc("ctl_all", `TCBR_OFS_CTL, 32'h8000_FFFF);
    wreg(`TCBR_OFS_CTL, 32'h0000_0800);
    rc("ctl_noest", `TCBR_OFS_CTL, 32'h8000_0800);
    wreg(`TCBR_OFS_CTL, 32'h0000_E203);
    rc("ctl_xfdt", `TCBR_OFS_CTL, 32'h0000_E203);
    chk("fdt_mode", 32'h5, {29'h0, fe, ne, cy});
    fm = 1'b1;
    cyc(1);
    fm = 1'b0;
    mt = 1'b1;
    chk("seq_fdt", 32'h2, {30'h0, sf, sb});
    cyc(1);
    chk("seq_bm", 32'h1, {30'h0, sf, sb});
    chk("dc_fdt", 32'h0, 32'(dc));
    cyc(1);
    mt = 1'b0;
    chk("dc_next", 32'h1, 32'(dc));
    cyc(2);
    wreg(`TCBR_OFS_CTL, 32'h0000_0E03);
    chk("er_fcr", 32'h3, {29'h0, ne, ee, ce});
    wreg(`TCBR_OFS_CTL, 32'h0000_1203);
    chk("bm_mode", 32'h2, {30'h0, be, ne});
    wreg(`TCBR_OFS_CTL, 32'h0000_0018);
    chk("ofc_half", 32'h22, {26'h0, oe, 2'h0, div});
    wreg(`TCBR_OFS_CTL, 32'h0000_0008);
    chk("ofc_quart", 32'h24, {26'h0, oe, 2'h0, div});
    wreg(`TCBR_OFS_CTL, 32'h0000_0010);
    chk("offchip_clock_ratio_only", 32'h4, {26'h0, oe, 2'h0, div});
    // normal tracing, then sync period of 256 instructions
    wreg(`TCBR_OFS_CTL, 32'h0000_0003);
    chk("normal", 32'h3, {30'h0, ne, co});
    n = 0;
    st = 1'b1;
    mt = 1'b1;
    for (int i = 0; i < 300; i++) begin
      @(posedge clk_in);
      #1 n += int'(sd);
    end
    st = 1'b0;
    mt = 1'b0;
    chk("sync_cnt", 32'h1, 32'(n));
    // store, read back and pointer stepping
    wreg(`TCBR_OFS_WRP, 32'h0);
    wreg(`TCBR_OFS_RDP, 32'h0);
    push(3);
    rc("wrp3", `TCBR_OFS_WRP, 32'h18);
    rc("hi0", `TCBR_OFS_WORD_HI, 32'hA5A5_0000);
    rc("rdp_hi", `TCBR_OFS_RDP, 32'h0);
    rc("lo0", `TCBR_OFS_WORD_LO, 32'h5A5A_0000);
    rc("rdp_lo", `TCBR_OFS_RDP, 32'h8);
    rc("hi1", `TCBR_OFS_WORD_HI, 32'hA5A5_0001);
    rc("lo1", `TCBR_OFS_WORD_LO, 32'h5A5A_0001);
    // stop collection flushes the partial word
    pv = 1'b1;
    wreg(`TCBR_OFS_CTL, 32'h0);
    chk("flush", 32'h1, {31'h0, fl});
    cyc(2);
    pv = 1'b0;
    rc("wrp_flush", `TCBR_OFS_WRP, 32'h20);
    wreg(`TCBR_OFS_RDP, 32'h18);
    rc("hi3", `TCBR_OFS_WORD_HI, 32'hFFFF_FFFF);
    rc("lo3", `TCBR_OFS_WORD_LO, 32'h0000_00C3);
    // trigger pins drive the enable bit without flushing
    wreg(`TCBR_OFS_CTL, 32'h0000_0001);
    on_t = 1'b1;
    cyc(1);
    on_t = 1'b0;
    cyc(5);
    rc("en_on", `TCBR_OFS_CTL, 32'h0000_0003);
    off_t = 1'b1;
    cyc(1);
    off_t = 1'b0;
    cyc(5);
    rc("en_off", `TCBR_OFS_CTL, 32'h0000_0001);
    rc("wrp_keep", `TCBR_OFS_WRP, 32'h20);
    // wrap of the last entry, full memory stall
    wreg(`TCBR_OFS_WRP, 32'h7F8);
    push(1);
    rc("wrp_wrap", `TCBR_OFS_WRP, 32'h8000_0000);
    wreg(`TCBR_OFS_RDP, 32'h0);
    wreg(`TCBR_OFS_CTL, 32'h0000_000D);
    chk("stall", 32'h1, {31'h0, stl});
    wreg(`TCBR_OFS_CTL, 32'h0000_0009);
    chk("no_stall", 32'h0, {31'h0, stl});
    wreg(`TCBR_OFS_WRP, 32'h0);
    rc("wrap_clr", `TCBR_OFS_WRP, 32'h0);
    // read pointer masking and wrap to zero
    wreg(`TCBR_OFS_RDP, 32'h0000_07FF);
    rc("rdp_mask", `TCBR_OFS_RDP, 32'h7F8);
    rc("lo_last", `TCBR_OFS_WORD_LO, 32'h5A5A_0000);
    rc("rdp_wrap", `TCBR_OFS_RDP, 32'h0);
    rc("unmapped", 14'h3FA0, 32'h0);
    end_of_test();
  end
endmodule : tb_trace_control_buffer_regs
`default_nettype wire
